// *** logic/ttx_cfg.svh ***
// Register offsets, field positions, reset values and slot timing counts
`ifndef TTX_CFG_SVH
`define TTX_CFG_SVH

`define TTX_CTL_ADDR        8'hc9
`define TELETEXT_REQUEST_ADDR        8'hca

`define TTX_CTL_EN_BIT      0
`define TTX_CTL_MODE_BIT    1
`define TTX_CTL_PSEL_BIT    2
`define TTX_CTL_BUSY_BIT    6
`define TTX_CTL_OVR_BIT     7
`define TTX_CTL_MASK_WIDE   8'h07
`define TTX_CTL_MASK_NARROW 8'h03
`define TTX_CTL_RST         8'h00

`define TTX_DLY_LSB         0
`define TTX_DLY_MSB         3
`define TTX_WID_LSB         4
`define TTX_WID_MSB         7
`define TELETEXT_REQUEST_RST         8'h00

`define TTX_SYS_KHZ         17'h0_9c40
`define TTX_PIX_KHZ         17'h0_6978

`define TTX_GRP_LAST_IDX    6'h24
`define TTX_LINE_LAST_BIT   9'h167
`define TTX_SHORT0          6'h09
`define TTX_SHORT1          6'h12
`define TTX_SHORT2          6'h1b
`define TTX_SHORT3          6'h24
`define TTX_SHORT_LAST      2'h2
`define TTX_LONG_LAST       2'h3
`define TTX_SAMPLE_CYC      2'h2
`define TTX_LCNT_MAX        5'h1f

`define TTX_FIFO_WIDTH      8
`define TTX_FIFO_DEPTH      8

`endif

// *** logic/ttx_pkg.sv ***
// Shared types of the teletext insertion port
package ttx_pkg;
	typedef enum logic [0:0] {
		TTX_IDLE,
		TTX_LINE
	} ttx_state_t;
endpackage

// *** logic/ttx_fifo.sv ***
// Byte FIFO between the teletext sampler and the VBI inserter
`timescale 1ns/100ps
module ttx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)(
	input  wire logic             sys_clk,   // System clock
	input  wire logic             rstn,      // Synchronous reset, low
	input  wire logic             in_valid,  // Write request
	output logic                  in_ready,  // Space available
	input  wire logic [WIDTH-1:0] in_data,   // Write data
	output logic                  out_valid, // Data available
	input  wire logic             out_ready, // Reader takes data
	output logic      [WIDTH-1:0] out_data   // Head of queue
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} ttx_fifo_st_t;

	ttx_fifo_st_t s_q;
	ttx_fifo_st_t s_d;
	logic         push;
	logic         pop;

	assign in_ready  = (s_q.cnt != FULL);
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];

	always_comb begin
		s_d  = s_q;
		push = in_valid && in_ready;
		pop  = out_valid && out_ready;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == LAST) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == LAST) ? '0 : s_q.rp + 1'b1;
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// *** logic/ttx_port.sv ***
// Teletext insertion port: request output, slot timing, sampling
`timescale 1ns/100ps
`include "ttx_cfg.svh"
module ttx_port #(
	parameter bit WIDE_PORT  = 1'b1,
	parameter int FIFO_DEPTH = `TTX_FIFO_DEPTH
)(
	input  wire logic       sys_clk,              // 40 MHz clock
	input  wire logic       rstn,                 // Sync reset, low
	input  wire logic       pal_mode,             // PAL standard selected
	input  wire logic       line_start,           // Teletext line begins
	input  wire logic [7:0] reg_addr,             // Register subaddress
	input  wire logic       reg_wr,               // Register write strobe
	input  wire logic [7:0] reg_wdata,            // Register write data
	output logic      [7:0] reg_rdata,            // Readback, one cycle late
	input  wire logic       vsync_data_pin,       // Teletext data on vsync
	input  wire logic       pixel_input_bit_zero, // Teletext data on P bit 0
	output logic            teletext_request_pin, // Request to source
	output logic      [7:0] ttx_byte,             // Collected byte
	output logic            ttx_byte_valid,       // Byte available
	input  wire logic       ttx_byte_ready,       // Consumer takes byte
	output logic            ttx_overrun,          // Byte lost, sticky
	output logic            ttx_busy              // Line in progress
);
	import ttx_pkg::*;

	localparam logic [7:0] CTL_MASK =
		WIDE_PORT ? `TTX_CTL_MASK_WIDE : `TTX_CTL_MASK_NARROW;

	typedef struct packed {
		logic [8:0] bit_n;
		logic [5:0] idx;
		logic [1:0] cyc;
	} ttx_slot_t;

	typedef struct packed {
		ttx_state_t st;
		logic [15:0] acc;
		logic [7:0]  ctl;
		logic [7:0]  rcfg;
		logic [7:0]  rdata;
		logic [1:0]  vs_sync;
		logic [1:0]  p0_sync;
		logic        pend;
		logic        req_on;
		ttx_slot_t   req;
		logic [4:0]  lcnt;
		logic        dwait;
		logic [3:0]  dly;
		logic        dat_on;
		ttx_slot_t   dat;
		logic [7:0]  shf;
		logic [2:0]  nbit;
		logic        wv;
		logic [7:0]  wd;
		logic        ovr;
		logic        req_pin;
	} ttx_port_st_t;

	ttx_port_st_t s_q;
	ttx_port_st_t s_d;
	logic [16:0]  sum;
	logic         pix_en;
	logic         en;
	logic         bmode;
	logic         psel;
	logic         din;
	logic [3:0]   dly_f;
	logic [4:0]   wid;
	logic [7:0]   shf_n;
	logic         fifo_in_ready;

	// Three cycles for the short bits of a group, four for the rest
	function automatic logic [1:0] slot_last(input logic [5:0] idx);
		if (idx == `TTX_SHORT0 || idx == `TTX_SHORT1 ||
		    idx == `TTX_SHORT2 || idx == `TTX_SHORT3) begin
			return `TTX_SHORT_LAST;
		end
		return `TTX_LONG_LAST;
	endfunction

	// Last-cycle test of the current slot
	function automatic logic slot_end(input ttx_slot_t s);
		return s.cyc == slot_last(s.idx);
	endfunction

	// One pixel tick along the 37-bit, 144-cycle pattern
	function automatic ttx_slot_t slot_step(input ttx_slot_t s);
		ttx_slot_t r;
		r = s;
		if (slot_end(s)) begin
			r.cyc   = 2'h0;
			r.idx   = (s.idx == `TTX_GRP_LAST_IDX) ? 6'h00 : s.idx + 6'h01;
			r.bit_n = s.bit_n + 9'h001;
		end else begin
			r.cyc = s.cyc + 2'h1;
		end
		return r;
	endfunction

	always_comb begin
		s_d    = s_q;
		pix_en = 1'b0;
		shf_n  = s_q.shf;
		s_d.wv = 1'b0;

		s_d.vs_sync = {s_q.vs_sync[0], vsync_data_pin};
		s_d.p0_sync = {s_q.p0_sync[0], pixel_input_bit_zero};

		// 27/40 fractional divider gives the pixel-rate enable
		sum = {1'b0, s_q.acc} + `TTX_PIX_KHZ;
		if (sum >= `TTX_SYS_KHZ) begin
			pix_en = 1'b1;
			s_d.acc = 16'(sum - `TTX_SYS_KHZ);
		end else begin
			s_d.acc = sum[15:0];
		end

		en    = s_q.ctl[`TTX_CTL_EN_BIT] && pal_mode;
		bmode = s_q.ctl[`TTX_CTL_MODE_BIT];
		psel  = WIDE_PORT && s_q.ctl[`TTX_CTL_PSEL_BIT];
		din   = psel ? s_q.p0_sync[1] : s_q.vs_sync[1];
		dly_f = s_q.rcfg[`TTX_DLY_MSB:`TTX_DLY_LSB];
		wid   = {1'b0, s_q.rcfg[`TTX_WID_MSB:`TTX_WID_LSB]} + 5'h01;

		if (reg_wr && reg_addr == `TTX_CTL_ADDR) begin
			s_d.ctl = reg_wdata & CTL_MASK;
			s_d.ovr = 1'b0;
		end
		if (reg_wr && reg_addr == `TELETEXT_REQUEST_ADDR) begin
			s_d.rcfg = reg_wdata;
		end

		unique case (s_q.st)
			TTX_IDLE: begin
				// A full FIFO refuses the line start; line_start is not kept, so that line is skipped
				if (en && line_start && fifo_in_ready) begin
					s_d.st     = TTX_LINE;
					s_d.pend   = 1'b1;
					s_d.req_on = 1'b0;
					s_d.dat_on = 1'b0;
					s_d.dwait  = 1'b0;
				end
			end
			TTX_LINE: begin
				if (!en) begin
					s_d.st     = TTX_IDLE;
					s_d.pend   = 1'b0;
					s_d.req_on = 1'b0;
					s_d.dat_on = 1'b0;
					s_d.dwait  = 1'b0;
				end else if (pix_en && s_q.pend) begin
					s_d.pend   = 1'b0;
					s_d.req_on = 1'b1;
					s_d.req    = '0;
					s_d.dat    = '0;
					s_d.lcnt   = 5'h00;
					s_d.nbit   = 3'h0;
					if (dly_f == 4'h0) begin
						s_d.dat_on = 1'b1;
					end else begin
						s_d.dwait = 1'b1;
						s_d.dly   = dly_f;
					end
				end else if (pix_en) begin
					if (s_q.req_on) begin
						s_d.req = slot_step(s_q.req);
						if (s_q.lcnt != `TTX_LCNT_MAX) begin
							s_d.lcnt = s_q.lcnt + 5'h01;
						end
						if (slot_end(s_q.req) &&
						    s_q.req.bit_n == `TTX_LINE_LAST_BIT) begin
							s_d.req_on = 1'b0;
						end
					end
					if (s_q.dwait) begin
						if (s_q.dly == 4'h1) begin
							s_d.dwait  = 1'b0;
							s_d.dat_on = 1'b1;
						end else begin
							s_d.dly = s_q.dly - 4'h1;
						end
					end
					if (s_q.dat_on) begin
						// Late in the slot: the pin arrives through the request
						// flop and two sync flops, about three cycles behind
						if (s_q.dat.cyc == `TTX_SAMPLE_CYC) begin
							shf_n    = {din, s_q.shf[7:1]};
							s_d.shf  = shf_n;
							s_d.nbit = s_q.nbit + 3'h1;
							if (s_q.nbit == 3'h7) begin
								s_d.wv = 1'b1;
								s_d.wd = shf_n;
							end
						end
						s_d.dat = slot_step(s_q.dat);
						if (slot_end(s_q.dat) &&
						    s_q.dat.bit_n == `TTX_LINE_LAST_BIT) begin
							s_d.dat_on = 1'b0;
							s_d.st     = TTX_IDLE;
						end
					end
				end
			end
		endcase

		// Loss is flagged after the clear so a coincident loss survives
		if (s_q.wv && !fifo_in_ready) begin
			s_d.ovr = 1'b1;
		end

		// Bit mode pulses are clipped by the slot, so wide settings merge
		if (bmode) begin
			s_d.req_pin = s_q.req_on && ({3'h0, s_q.req.cyc} < wid);
		end else begin
			s_d.req_pin = s_q.req_on && (s_q.lcnt < wid);
		end

		unique case (reg_addr)
			`TTX_CTL_ADDR: begin
				s_d.rdata = s_q.ctl;
				s_d.rdata[`TTX_CTL_OVR_BIT]  = s_q.ovr;
				s_d.rdata[`TTX_CTL_BUSY_BIT] = (s_q.st == TTX_LINE);
			end
			`TELETEXT_REQUEST_ADDR: begin
				s_d.rdata = s_q.rcfg;
			end
			default: begin
				s_d.rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	ttx_fifo #(
		.WIDTH (`TTX_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_valid  (s_q.wv),
		.in_ready  (fifo_in_ready),
		.in_data   (s_q.wd),
		.out_valid (ttx_byte_valid),
		.out_ready (ttx_byte_ready),
		.out_data  (ttx_byte)
	);

	assign teletext_request_pin = s_q.req_pin;
	assign reg_rdata            = s_q.rdata;
	assign ttx_overrun          = s_q.ovr;
	assign ttx_busy             = (s_q.st == TTX_LINE);
endmodule

// *** dv/ttx_port_sva.sv ***
// Concurrent checks on the teletext insertion port
`timescale 1ns/100ps
module ttx_port_sva (
	input wire logic       sys_clk,              // Clock
	input wire logic       rstn,                 // Reset, low
	input wire logic       pal_mode,             // PAL selected
	input wire logic       line_start,           // Line begins
	input wire logic [7:0] reg_addr,             // Subaddress
	input wire logic       reg_wr,               // Write strobe
	input wire logic [7:0] reg_wdata,            // Write data
	input wire logic       teletext_request_pin, // Request
	input wire logic       ttx_byte_valid,       // Byte ready
	input wire logic       ttx_busy              // Line running
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [7:0]  ctl_q;
	logic [7:0]  cfg_q;
	logic [11:0] hi_q;
	logic [11:0] bsy_q;
	int          wlo;
	int          blo;
	// Request width in ticks, widened to cycles of the faster clock
	assign wlo = (cfg_q[7:4] + 1) * 40 / 27 - 1;
	assign blo = (1402 + cfg_q[3:0]) * 40 / 27 - 3;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctl_q <= 8'h00;
			cfg_q <= 8'h00;
		end else if (reg_wr && reg_addr == 8'hc9) begin
			ctl_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'hca) begin
			cfg_q <= reg_wdata;
		end
	end
	always_ff @(posedge sys_clk) begin
		hi_q <= teletext_request_pin ? hi_q + 12'h001 : 12'h000;
		bsy_q <= ttx_busy ? bsy_q + 12'h001 : 12'h000;
	end
	AST_START: assert property (line_start && !ttx_busy && pal_mode
		&& ctl_q[0] && !ttx_byte_valid |=> ttx_busy)
		else $error("line not started");
	AST_NO_START: assert property (line_start && !ttx_busy
		&& !(pal_mode && ctl_q[0]) |=> !ttx_busy)
		else $error("line started while disabled");
	AST_ABORT: assert property (ttx_busy && !(pal_mode && ctl_q[0])
		|=> !ttx_busy)
		else $error("line not aborted");
	AST_IDLE_REQ: assert property (!ttx_busy [*3]
		|-> !teletext_request_pin)
		else $error("request while idle");
	AST_REQ_RISE: assert property ($rose(ttx_busy) && pal_mode
		&& ctl_q[0] |-> ##[0:3] teletext_request_pin)
		else $error("no request after start");
	AST_LINE_WIDTH: assert property ($fell(teletext_request_pin)
		&& !ctl_q[1] && ttx_busy |-> hi_q >= wlo && hi_q <= wlo + 3)
		else $error("line request width wrong");
	AST_LINE_LEN: assert property ($fell(ttx_busy) && $past(pal_mode)
		&& ctl_q[0] |-> bsy_q >= blo && bsy_q <= blo + 11)
		else $error("line length wrong");
	AST_BIT_PULSE: assert property (ctl_q[1] && cfg_q[7:4] == 4'h0
		&& teletext_request_pin && $past(teletext_request_pin)
		|-> !$past(teletext_request_pin, 2))
		else $error("bit request too long");
endmodule
bind ttx_port ttx_port_sva chk_i (
	.sys_clk(sys_clk), .rstn(rstn), .pal_mode(pal_mode),
	.line_start(line_start), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .teletext_request_pin(teletext_request_pin),
	.ttx_byte_valid(ttx_byte_valid), .ttx_busy(ttx_busy));

// *** dv/ttx_src_model.sv ***
// Teletext source model: answers a request with one line of bits
`timescale 1ns/100ps
module ttx_src_model (
	input  wire logic sys_clk, // Clock
	input  wire logic req,     // Request from the port
	input  wire logic val,     // Level of every bit of the line
	output logic      data     // Serial data
);
	logic [11:0] left_q = 12'h000;
	logic        req_q = 1'b0;
	// one level held across every slot of a line
	// Every rising request edge re-arms, so an aborted line cannot cut the next
	always @(posedge sys_clk) begin
		req_q <= req;
		if (req && !req_q) begin
			left_q <= 12'h0866;
		end else if (left_q != 12'h000) begin
			left_q <= left_q - 12'h001;
		end
	end
	// Level follows the request at once, so a zero delay is met;
	// released between lines it shows the inverse, never a stale level
	assign data = (req || left_q != 12'h000) ? val : ~val;
endmodule

// *** dv/tb_teletext_insertion_port.sv ***
// Self-checking bench for the teletext insertion port
`timescale 1ns/100ps
module tb_teletext_insertion_port;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       pal = 1'b1;
	logic       ls = 1'b0;
	logic [7:0] addr = 8'h00;
	logic       wr_en = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic       rdy = 1'b1;
	logic       val = 1'b1;
	logic       pix = 1'b0;
	logic [7:0] rdata;
	logic [7:0] byte_d;
	logic       req;
	logic       src_d;
	logic       vld;
	logic       busy;
	logic       ovr;
	logic [7:0] got [$];
	int         err_total = 0;
	int         num_checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	ttx_port dut (.sys_clk(sys_clk), .rstn(rstn), .pal_mode(pal),
		.line_start(ls), .reg_addr(addr), .reg_wr(wr_en),
		.reg_wdata(wdata), .reg_rdata(rdata),
		.vsync_data_pin(pix ? ~src_d : src_d),
		.pixel_input_bit_zero(pix ? src_d : ~src_d),
		.teletext_request_pin(req), .ttx_byte(byte_d),
		.ttx_byte_valid(vld), .ttx_byte_ready(rdy),
		.ttx_overrun(ovr), .ttx_busy(busy));
	ttx_src_model src (.sys_clk(sys_clk), .req(req), .val(val),
		.data(src_d));
	always @(posedge sys_clk) if (vld === 1'b1 && rdy) got.push_back(byte_d);
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		repeat (2) @(posedge sys_clk);
		chk(rdata, e);
	endtask
	task automatic go;
		@(posedge sys_clk);
		ls <= 1'b1;
		@(posedge sys_clk);
		ls <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic idle;
		for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge sys_clk);
		repeat (30) @(posedge sys_clk);
		chk({7'h00, busy}, 8'h00);
	endtask
	task automatic t_regs;
		rd(8'hc9, 8'h00);
		rd(8'hca, 8'h00);
		wr(8'hc9, 8'hff);
		rd(8'hc9, 8'h07);
		wr(8'hca, 8'ha5);
		rd(8'hca, 8'ha5);
		rd(8'hcb, 8'h00);
	endtask
	task automatic t_refuse;
		pal <= 1'b0;
		wr(8'hc9, 8'h01);
		go();
		chk({7'h00, busy}, 8'h00);
		pal <= 1'b1;
		wr(8'hc9, 8'h00);
		go();
		chk({7'h00, busy}, 8'h00);
	endtask
	task automatic t_line(input logic [7:0] c, input logic [7:0] f,
		input logic v);
		val <= v;
		pix <= c[2];
		wr(8'hca, f);
		wr(8'hc9, c);
		got.delete();
		go();
		chk({7'h00, busy}, 8'h01);
		idle();
		chk(8'(got.size()), 8'h2d);
		foreach (got[i]) chk(got[i], {8{v}});
	endtask
	task automatic t_abort;
		go();
		repeat (100) @(posedge sys_clk);
		pal <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({6'h00, busy, req}, 8'h00);
		pal <= 1'b1;
	endtask
	task automatic t_ovr;
		rdy <= 1'b0;
		got.delete();
		go();
		idle();
		chk({7'h00, ovr}, 8'h01);
		rd(8'hc9, 8'h85);
		wr(8'hc9, 8'h01);
		rd(8'hc9, 8'h01);
		chk({7'h00, ovr}, 8'h00);
		rdy <= 1'b1;
		repeat (20) @(posedge sys_clk);
		chk(8'(got.size()), 8'h08);
		foreach (got[i]) chk(got[i], 8'h00);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#600000;
		err_total++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_refuse();
		t_line(8'h01, 8'hf0, 1'b1);
		t_line(8'h07, 8'h0f, 1'b1);
		t_line(8'h05, 8'h33, 1'b0);
		t_abort();
		idle();
		t_ovr();
		close_out();
	end
endmodule
